// ---- rtl/aif_defs.vh ----
/*
 conversion event status register: offset, reset value, field positions.
 assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef AIF_DEFS_VH
`define AIF_DEFS_VH

// register offset and reset value
`define AIF_STATUS_OFFSET     8'h64
`define AIF_STATUS_RESET      32'h00000000

// field positions inside the 32-bit register image
`define AIF_CH6_DONE_BIT      6
`define AIF_CH7_DONE_BIT      7
`define AIF_CH8_DONE_BIT      8
`define AIF_CH9_DONE_BIT      9
`define AIF_CH10_DONE_BIT     10
`define AIF_CH11_DONE_BIT     11
`define AIF_CH12_DONE_BIT     12
`define AIF_EXC_IRQ_MEAS_BIT  16
`define AIF_EXC_SEQ_MEAS_BIT  17
`define AIF_DIFF1_LOWER_BIT   24
`define AIF_DIFF1_UPPER_BIT   25

// number of flags held by this block
`define AIF_FLAG_COUNT        11
`define AIF_FLAG_RESET        11'h000

`endif

// ---- rtl/aif_status_flags.v ----
/*
 sticky conversion event flags of the ten bit converter status register.
 assumes one clock, event inputs synchronous to clk_sys_i, and a simple
 register port with read data valid in the cycle after the read strobe.
*/
// The placing of the registers and the strobed register port were chosen for this implementation.
//
// Contract
// - channel 6 done sets bit 6
// - channel 7 done sets bit 7
// - channel 8 done sets bit 8
// - channel 9 done sets bit 9
// - channel 10 done sets bit 10
// - channel 11 done sets bit 11
// - channel 12 done sets bit 12
// - exceptional interrupt measurement sets bit 16
// - exceptional sequence measurement sets bit 17
// - differential unit one lower sets bit 24
// - differential unit one upper sets bit 25
// - register at 0x64, resets to zero
`timescale 1ns/10ps
`default_nettype none
`include "aif_defs.vh"

module aif_status_flags (
   // clock and reset
   input  wire        clk_sys_i,
   input  wire        rst_i,
   // register port
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   // converter events, one-cycle pulses
   input  wire [6:0]  ch_done_i,
   input  wire        exc_irq_meas_i,
   input  wire        exc_seq_meas_i,
   input  wire        diff1_lower_done_i,
   input  wire        diff1_upper_done_i,
   // flag state for the enable logic outside
   output reg  [10:0] flags_o
);

////////////////////////////////////////////////////////////////////////////
// flag vector order, shared by flags_o and the enable logic outside;
// the flags of channels 0..5 and diff units 2..4 live elsewhere
// an event input held high keeps setting its flag every cycle

localparam FLG_CH6      = 0;
localparam FLG_CH7      = 1;
localparam FLG_CH8      = 2;
localparam FLG_CH9      = 3;
localparam FLG_CH10     = 4;
localparam FLG_CH11     = 5;
localparam FLG_CH12     = 6;
localparam FLG_IRQ_MEAS = 7;
localparam FLG_SEQ_MEAS = 8;
localparam FLG_DIFF1_LO = 9;
localparam FLG_DIFF1_UP = 10;

////////////////////////////////////////////////////////////////////////////
// helper functions

// sticky update: the set term is or-ed in after the clear, so a
// converter event in the same cycle as a clearing write is kept
function aif_sticky;
   input old_flag;
   input set_ev;
   input clr_req;
   begin
      aif_sticky = (old_flag & ~clr_req) | set_ev;
   end
endfunction

// write one to clear: a zero in the written word leaves the flag alone
function aif_clear_bit;
   input         wr_sel;
   input  [31:0] data;
   input integer pos;
   begin
      aif_clear_bit = wr_sel & data[pos];
   end
endfunction

// pack the held flags into the 32-bit image; unlisted bits stay zero
function [31:0] aif_image;
   input [10:0] f;
   begin
      aif_image = `AIF_STATUS_RESET;
      aif_image[`AIF_CH6_DONE_BIT]     = f[0];
      aif_image[`AIF_CH7_DONE_BIT]     = f[1];
      aif_image[`AIF_CH8_DONE_BIT]     = f[2];
      aif_image[`AIF_CH9_DONE_BIT]     = f[3];
      aif_image[`AIF_CH10_DONE_BIT]    = f[4];
      aif_image[`AIF_CH11_DONE_BIT]    = f[5];
      aif_image[`AIF_CH12_DONE_BIT]    = f[6];
      aif_image[`AIF_EXC_IRQ_MEAS_BIT] = f[7];
      aif_image[`AIF_EXC_SEQ_MEAS_BIT] = f[8];
      aif_image[`AIF_DIFF1_LOWER_BIT]  = f[9];
      aif_image[`AIF_DIFF1_UPPER_BIT]  = f[10];
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// register port decode

wire        wr_hit;
wire        rd_hit;

// only the one offset is mapped; every other address is ignored
assign wr_hit = wr_i & (addr_i == `AIF_STATUS_OFFSET);
assign rd_hit = rd_i & (addr_i == `AIF_STATUS_OFFSET);

////////////////////////////////////////////////////////////////////////////
// channel 6 conversion finished

wire        set_ch6;
wire        clr_ch6;
reg         ch6_next;

assign set_ch6 = ch_done_i[0];
assign clr_ch6 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH6_DONE_BIT);

always @* begin
   ch6_next = flags_o[FLG_CH6];
   if (set_ch6 | clr_ch6) begin
      ch6_next = aif_sticky(flags_o[FLG_CH6],
                            set_ch6, clr_ch6);
   end
end

////////////////////////////////////////////////////////////////////////////
// channel 7 conversion finished

wire        set_ch7;
wire        clr_ch7;
reg         ch7_next;

assign set_ch7 = ch_done_i[1];
assign clr_ch7 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH7_DONE_BIT);

always @* begin
   ch7_next = flags_o[FLG_CH7];
   if (set_ch7 | clr_ch7) begin
      ch7_next = aif_sticky(flags_o[FLG_CH7],
                            set_ch7, clr_ch7);
   end
end

////////////////////////////////////////////////////////////////////////////
// channel 8 conversion finished

wire        set_ch8;
wire        clr_ch8;
reg         ch8_next;

assign set_ch8 = ch_done_i[2];
assign clr_ch8 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH8_DONE_BIT);

always @* begin
   ch8_next = flags_o[FLG_CH8];
   if (set_ch8 | clr_ch8) begin
      ch8_next = aif_sticky(flags_o[FLG_CH8],
                            set_ch8, clr_ch8);
   end
end

////////////////////////////////////////////////////////////////////////////
// channel 9 conversion finished

wire        set_ch9;
wire        clr_ch9;
reg         ch9_next;

assign set_ch9 = ch_done_i[3];
assign clr_ch9 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH9_DONE_BIT);

always @* begin
   ch9_next = flags_o[FLG_CH9];
   if (set_ch9 | clr_ch9) begin
      ch9_next = aif_sticky(flags_o[FLG_CH9],
                            set_ch9, clr_ch9);
   end
end

////////////////////////////////////////////////////////////////////////////
// channel 10 conversion finished

wire        set_ch10;
wire        clr_ch10;
reg         ch10_next;

assign set_ch10 = ch_done_i[4];
assign clr_ch10 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH10_DONE_BIT);

always @* begin
   ch10_next = flags_o[FLG_CH10];
   if (set_ch10 | clr_ch10) begin
      ch10_next = aif_sticky(flags_o[FLG_CH10],
                             set_ch10, clr_ch10);
   end
end

////////////////////////////////////////////////////////////////////////////
// channel 11 conversion finished

wire        set_ch11;
wire        clr_ch11;
reg         ch11_next;

assign set_ch11 = ch_done_i[5];
assign clr_ch11 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH11_DONE_BIT);

always @* begin
   ch11_next = flags_o[FLG_CH11];
   if (set_ch11 | clr_ch11) begin
      ch11_next = aif_sticky(flags_o[FLG_CH11],
                             set_ch11, clr_ch11);
   end
end

////////////////////////////////////////////////////////////////////////////
// channel 12 conversion finished

wire        set_ch12;
wire        clr_ch12;
reg         ch12_next;

assign set_ch12 = ch_done_i[6];
assign clr_ch12 = aif_clear_bit(wr_hit, wdata_i, `AIF_CH12_DONE_BIT);

always @* begin
   ch12_next = flags_o[FLG_CH12];
   if (set_ch12 | clr_ch12) begin
      ch12_next = aif_sticky(flags_o[FLG_CH12],
                             set_ch12, clr_ch12);
   end
end

////////////////////////////////////////////////////////////////////////////
// exceptional interrupt measurement

wire        set_irq_meas;
wire        clr_irq_meas;
reg         irq_meas_next;

assign set_irq_meas = exc_irq_meas_i;
assign clr_irq_meas = aif_clear_bit(wr_hit, wdata_i, `AIF_EXC_IRQ_MEAS_BIT);

always @* begin
   irq_meas_next = flags_o[FLG_IRQ_MEAS];
   if (set_irq_meas | clr_irq_meas) begin
      irq_meas_next = aif_sticky(flags_o[FLG_IRQ_MEAS],
                                 set_irq_meas, clr_irq_meas);
   end
end

////////////////////////////////////////////////////////////////////////////
// exceptional sequence measurement

wire        set_seq_meas;
wire        clr_seq_meas;
reg         seq_meas_next;

assign set_seq_meas = exc_seq_meas_i;
assign clr_seq_meas = aif_clear_bit(wr_hit, wdata_i, `AIF_EXC_SEQ_MEAS_BIT);

always @* begin
   seq_meas_next = flags_o[FLG_SEQ_MEAS];
   if (set_seq_meas | clr_seq_meas) begin
      seq_meas_next = aif_sticky(flags_o[FLG_SEQ_MEAS],
                                 set_seq_meas, clr_seq_meas);
   end
end

////////////////////////////////////////////////////////////////////////////
// first differential unit, lower channel

wire        set_diff1_lo;
wire        clr_diff1_lo;
reg         diff1_lo_next;

assign set_diff1_lo = diff1_lower_done_i;
assign clr_diff1_lo = aif_clear_bit(wr_hit, wdata_i, `AIF_DIFF1_LOWER_BIT);

always @* begin
   diff1_lo_next = flags_o[FLG_DIFF1_LO];
   if (set_diff1_lo | clr_diff1_lo) begin
      diff1_lo_next = aif_sticky(flags_o[FLG_DIFF1_LO],
                                 set_diff1_lo, clr_diff1_lo);
   end
end

////////////////////////////////////////////////////////////////////////////
// first differential unit, upper channel

wire        set_diff1_up;
wire        clr_diff1_up;
reg         diff1_up_next;

assign set_diff1_up = diff1_upper_done_i;
assign clr_diff1_up = aif_clear_bit(wr_hit, wdata_i, `AIF_DIFF1_UPPER_BIT);

always @* begin
   diff1_up_next = flags_o[FLG_DIFF1_UP];
   if (set_diff1_up | clr_diff1_up) begin
      diff1_up_next = aif_sticky(flags_o[FLG_DIFF1_UP],
                                 set_diff1_up, clr_diff1_up);
   end
end

////////////////////////////////////////////////////////////////////////////
// flag vector and read image

reg  [10:0] flags_next;
reg  [31:0] rdata_next;

// reserved positions have no storage, so a write there changes nothing
always @* begin
   flags_next = {diff1_up_next, diff1_lo_next, seq_meas_next,
                 irq_meas_next, ch12_next, ch11_next, ch10_next,
                 ch9_next, ch8_next, ch7_next, ch6_next};
end

// the image is taken before the edge: an event in the read cycle shows
// on the next read, never half-way
always @* begin
   if (rd_hit) begin
      rdata_next = aif_image(flags_o);
   end else begin
      rdata_next = `AIF_STATUS_RESET;
   end
end

////////////////////////////////////////////////////////////////////////////
// registers

// read data falls back to zero after one cycle, so no stale word lingers
always @(posedge clk_sys_i or posedge rst_i) begin
   if (rst_i) begin
      flags_o <= `AIF_FLAG_RESET;
      rdata_o <= `AIF_STATUS_RESET;
   end else begin
      flags_o <= flags_next;
      rdata_o <= rdata_next;
   end
end

endmodule

`default_nettype wire

// ---- verification/aif_props.sv ----
/* flag register checker; assumes the bench binds it onto the block ports */
`timescale 1ns/10ps
`default_nettype none
module aif_props (input wire clk_sys_i, rst_i, wr_i, rd_i, exc_irq_meas_i,
   input wire exc_seq_meas_i, diff1_lower_done_i, diff1_upper_done_i,
   input wire [7:0] addr_i, input wire [6:0] ch_done_i,
   input wire [10:0] flags_o, input wire [31:0] wdata_i, rdata_o);
   wire [10:0] ev = {diff1_upper_done_i, diff1_lower_done_i,
      exc_seq_meas_i, exc_irq_meas_i, ch_done_i};
   wire        h = addr_i == 8'h64;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_flag_set: assert property
      (|ev |=> (flags_o & $past(ev)) == $past(ev)) else $error("flag unset");
   a_no_spur: assert property
      (1 |=> !(flags_o & ~$past(flags_o) & ~$past(ev))) else $error("spur");
   a_no_lost: assert property
      (!(wr_i && h) |=> !($past(flags_o) & ~flags_o)) else $error("lost");
   a_wr_clear: assert property
      (wr_i && h && &wdata_i && !ev |=> !flags_o) else $error("no clear");
   a_rd_flag: assert property (rd_i && h |=>
      {rdata_o[25:24], rdata_o[17:16], rdata_o[12:6]} == $past(flags_o))
      else $error("read image");
   a_rd_once: assert property
      (rd_i ##1 !rd_i |=> !rdata_o) else $error("stale data");
   a_rd_unmap: assert property
      (rd_i && !h |=> !rdata_o) else $error("unmapped data");
   a_rsvd_zero: assert property
      (!(rdata_o & 32'hFCFCE03F)) else $error("reserved set");
endmodule
`default_nettype wire

// ---- verification/aif_status_flags_tb.sv ----
/* bench of the flag register; it drives every block input itself */
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
   n_fail++; $display("BAD %s %h %h", n, e, s); end end
module aif_status_flags_tb;
   logic        clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
   logic [7:0]  addr_i = 8'h00;
   logic [10:0] flags_o, ev = 11'h000;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   int          n_fail = 0, comparisons = 0, cyc = 0;
   int          pos[11] = '{6, 7, 8, 9, 10, 11, 12, 16, 17, 24, 25};
   aif_status_flags uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .flags_o(flags_o),
      .ch_done_i(ev[6:0]), .exc_irq_meas_i(ev[7]),
      .exc_seq_meas_i(ev[8]), .diff1_lower_done_i(ev[9]),
      .diff1_upper_done_i(ev[10]));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (++cyc > 500) begin n_fail++; wrap_up; end
   // event pulse rides with the strobe, so set and clear can coincide
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic [10:0] e);
      @(posedge clk_sys_i) {wr_i, rd_i, ev} <= {w, !w, e};
      {addr_i, wdata_i} <= {a, d};
      @(posedge clk_sys_i) {wr_i, rd_i, ev} <= 13'h0000;
      #1;
   endtask
   task automatic s_flags;
      for (int i = 0; i < 11; i++) begin
         acc(1, 8'h64, 32'hFFFFFFFF, 11'h001 << i);
         acc(1, 8'h60, 32'hFFFFFFFF, 11'h000);
         acc(0, 8'h64, 32'h0, 11'h000);
         `CK("flag", 32'h1 << pos[i], rdata_o)
         `CK("flags", 11'h001 << i, flags_o)
         acc(0, 8'h60, 32'h0, 11'h000);
      end
   endtask
   task automatic s_reset;
      acc(0, 8'h64, 32'h0, 11'h000);
      `CK("rst_rd", 32'h0, rdata_o)
      `CK("rst_flags", 11'h000, flags_o)
   endtask
   task automatic s_clear;
      acc(0, 8'h60, 32'h0, 11'h7FF);
      `CK("all_set", 11'h7FF, flags_o)
      acc(1, 8'h64, 32'h0, 11'h000);
      acc(1, 8'h64, 32'hFCFCE03F, 11'h000);
      `CK("kept", 11'h7FF, flags_o)
      acc(0, 8'h64, 32'h0, 11'h000);
      `CK("image", 32'h03031FC0, rdata_o)
      acc(1, 8'h64, 32'hFFFFFFFF, 11'h000);
      `CK("cleared", 11'h000, flags_o)
   endtask
   task automatic s_midreset;
      acc(0, 8'h60, 32'h0, 11'h7FF);
      @(posedge clk_sys_i) rst_i <= 1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 0;
      #1;
      `CK("mid_rst", 11'h000, flags_o)
      acc(0, 8'h64, 32'h0, 11'h000);
      `CK("mid_rd", 32'h0, rdata_o)
   endtask
   task automatic wrap_up;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 0;
      s_reset;
      s_flags;
      s_clear;
      s_midreset;
      wrap_up;
   end
endmodule
bind aif_status_flags aif_props chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .wr_i(wr_i), .rd_i(rd_i), .exc_irq_meas_i(exc_irq_meas_i),
   .exc_seq_meas_i(exc_seq_meas_i), .diff1_lower_done_i(diff1_lower_done_i),
   .diff1_upper_done_i(diff1_upper_done_i), .addr_i(addr_i),
   .ch_done_i(ch_done_i), .flags_o(flags_o), .wdata_i(wdata_i),
   .rdata_o(rdata_o));
`default_nettype wire
